// File: common/rcf_pkg.sv
package rcf_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] RCF_OFS_BORCTL = 4'h0;
  localparam logic [3:0] RCF_OFS_LOW    = 4'h1;
  localparam logic [3:0] RCF_OFS_HIGH   = 4'h2;
  localparam logic [3:0] RCF_OFS_STAT   = 4'h3;
  localparam logic [3:0] RCF_OFS_EVT    = 4'h4;
  localparam logic [3:0] RCF_OFS_MASK   = 4'h5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RCF_BIT_OVF    = 7;
  localparam int RCF_BIT_UNF    = 6;
  localparam int RCF_BIT_WV     = 5;
  localparam int RCF_BIT_WDT    = 4;
  localparam int RCF_BIT_EXT    = 3;
  localparam int RCF_BIT_RI     = 2;
  localparam int RCF_BIT_POR    = 1;
  localparam int RCF_BIT_BOR    = 0;
  localparam int RCF_BIT_MEMORY_VIOLATION_FLAG   = 1;
  localparam int RCF_BIT_SOFTWARE_BROWNOUT_ENABLE = 7;
  localparam int RCF_BIT_BROWNOUT_READY = 0;
  localparam int RCF_BIT_TO     = 6;
  localparam int RCF_BIT_PD     = 5;

  // ----------------------------------------------------------------
  // reset and load values
  // ----------------------------------------------------------------
  localparam logic [7:0] RCF_LOW_POR     = 8'h3c;
  localparam logic [7:0] RCF_LOW_BOR     = 8'h3c;
  localparam logic [7:0] RCF_STAT_POR    = 8'h60;
  localparam logic [7:0] RCF_STAT_MASK   = 8'h7f;
  localparam logic [7:0] RCF_HIGH_MASK   = 8'h02;
  localparam logic [7:0] RCF_BORCTL_RST  = 8'h80;
  localparam logic [9:0] RCF_EVT_RST     = 10'h000;

  // event indices, also status and mask bit positions
  localparam int RCF_EV_POR    = 0;
  localparam int RCF_EV_BOR    = 1;
  localparam int RCF_EV_EXT    = 2;
  localparam int RCF_EV_EXTSLP = 3;
  localparam int RCF_EV_WDT    = 4;
  localparam int RCF_EV_WV     = 5;
  localparam int RCF_EV_RI     = 6;
  localparam int RCF_EV_OVF    = 7;
  localparam int RCF_EV_UNF    = 8;
  localparam int RCF_EV_MEMORY_VIOLATION_FLAG   = 9;
  localparam int RCF_NEV       = 10;

  typedef struct packed {
    logic power_on;
    logic brownout;
    logic ext_awake;
    logic ext_sleep;
    logic wdt_timeout;
    logic window_violation;
    logic reset_instr;
    logic stack_overflow;
    logic stack_underflow;
    logic memory_violation;
  } rcf_cause_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcf_bus_s;

endpackage : rcf_pkg

// File: hdl/rcf_top.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - only the causing reset's flags change
// RULE_02 - hardware never returns flags to inactive
// RULE_03 - firmware may force flags active, no reset
// RULE_04 - power-on loads 0011110x, status -1100000, memory ok
// RULE_05 - brown-out loads 001111u0, same status image
// RULE_06 - external pin awake clears external flag only
// RULE_07 - external pin asleep also loads status -10uuuuu
// RULE_08 - watchdog timeout clears bit 4, status -0uuuuuu
// RULE_09 - closed-window watchdog clear clears bit 5
// RULE_10 - reset instruction clears bit 2 only
// RULE_11 - enabled stack overflow sets bit 7
// RULE_12 - enabled stack underflow sets bit 6
// RULE_13 - memory violation clears high register bit 1
// RULE_14 - stack flags active high, others active low
// RULE_15 - high register bits 7-2 and 0 read zero
// RULE_16 - stack resets need stack error enable
// RULE_17 - hardware update beats simultaneous firmware write
module rcf_top
  import rcf_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire rcf_cause_s cause_in,
  input  wire logic       stack_error_reset_enable,
  input  wire logic       brownout_ready,
  input  wire rcf_bus_s   bus_in,
  output logic [7:0]      rd_data,
  output logic            reset_req,
  output logic            pc_clear,
  output logic            irq
);

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_n_reg;
  rcf_cause_s cause_meta_reg;
  rcf_cause_s cause_sync_reg;
  rcf_cause_s cause_prev_reg;
  logic [1:0] en_sync_reg;
  logic [1:0] rdy_sync_reg;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // cause inputs are asynchronous sources; two stages before use
  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      cause_meta_reg <= '0;
      cause_sync_reg <= '0;
      cause_prev_reg <= '0;
      en_sync_reg    <= 2'b00;
      rdy_sync_reg   <= 2'b00;
    end
    else
    begin
      cause_meta_reg <= cause_in;
      cause_sync_reg <= cause_meta_reg;
      cause_prev_reg <= cause_sync_reg;
      en_sync_reg    <= {en_sync_reg[0], stack_error_reset_enable};
      rdy_sync_reg   <= {rdy_sync_reg[0], brownout_ready};
    end
  end

  // ----------------------------------------------------------------
  // cause vector ordering
  // ----------------------------------------------------------------
  // the struct lists causes msb first while event indices count up from
  // bit 0; mapping by field name keeps the two orders independent
  function automatic logic [RCF_NEV-1:0] cause_vec(input rcf_cause_s c);
    logic [RCF_NEV-1:0] v;
    v                = '0;
    v[RCF_EV_POR]    = c.power_on;
    v[RCF_EV_BOR]    = c.brownout;
    v[RCF_EV_EXT]    = c.ext_awake;
    v[RCF_EV_EXTSLP] = c.ext_sleep;
    v[RCF_EV_WDT]    = c.wdt_timeout;
    v[RCF_EV_WV]     = c.window_violation;
    v[RCF_EV_RI]     = c.reset_instr;
    v[RCF_EV_OVF]    = c.stack_overflow;
    v[RCF_EV_UNF]    = c.stack_underflow;
    v[RCF_EV_MEMORY_VIOLATION_FLAG]   = c.memory_violation;
    return v;
  endfunction : cause_vec

  // ----------------------------------------------------------------
  // cause edge detection
  // ----------------------------------------------------------------
  logic [RCF_NEV-1:0] lvl_now;
  logic [RCF_NEV-1:0] lvl_prev;
  logic [RCF_NEV-1:0] ev;
  logic               stack_en;

  assign lvl_now  = cause_vec(cause_sync_reg);
  assign lvl_prev = cause_vec(cause_prev_reg);
  assign stack_en = en_sync_reg[1];

  // a held level counts once; the source must drop before it repeats
  always_comb
  begin
    ev                = lvl_now & ~lvl_prev;
    ev[RCF_EV_OVF]    = ev[RCF_EV_OVF] & stack_en; // RULE_16
    ev[RCF_EV_UNF]    = ev[RCF_EV_UNF] & stack_en; // RULE_16
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  function automatic logic hit_wr(input rcf_bus_s b, input logic [3:0] ofs);
    hit_wr = b.wr && (b.addr == ofs);
  endfunction : hit_wr

  // ----------------------------------------------------------------
  // first flag register
  // ----------------------------------------------------------------
  logic [7:0] low_reg;
  logic [7:0] low_next;

  always_comb
  begin
    low_next = low_reg;
    // firmware may write any value, forcing a flag active starts nothing
    if (hit_wr(bus_in, RCF_OFS_LOW))
      low_next = bus_in.wdata; // RULE_03
    // hardware applied after the write so it wins on the same bit
    if (ev[RCF_EV_POR])
      low_next = RCF_LOW_POR; // RULE_04
    else if (ev[RCF_EV_BOR])
      low_next = {RCF_LOW_BOR[7:2], low_next[RCF_BIT_POR], 1'b0}; // RULE_05
    else
    begin
      // only the bit of the cause moves; the rest hold // RULE_01
      if (ev[RCF_EV_EXT] || ev[RCF_EV_EXTSLP])
        low_next[RCF_BIT_EXT] = 1'b0; // RULE_06 RULE_07
      if (ev[RCF_EV_WDT])
        low_next[RCF_BIT_WDT] = 1'b0; // RULE_08
      if (ev[RCF_EV_WV])
        low_next[RCF_BIT_WV] = 1'b0; // RULE_09
      if (ev[RCF_EV_RI])
        low_next[RCF_BIT_RI] = 1'b0; // RULE_10
      if (ev[RCF_EV_OVF])
        low_next[RCF_BIT_OVF] = 1'b1; // RULE_11 RULE_14
      if (ev[RCF_EV_UNF])
        low_next[RCF_BIT_UNF] = 1'b1; // RULE_12 RULE_14
    end
  end // RULE_17

  // apart from the power-on and brown-out loads, hardware never drives a flag back to its inactive level // RULE_02
  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      low_reg <= RCF_LOW_POR;
    else
      low_reg <= low_next;
  end

  // ----------------------------------------------------------------
  // second flag register
  // ----------------------------------------------------------------
  logic memory_violation_flag_reg;
  logic memory_violation_flag_next;

  // firmware value first, hardware cause last so it wins the bit
  always_comb
  begin
    memory_violation_flag_next = memory_violation_flag_reg;
    if (hit_wr(bus_in, RCF_OFS_HIGH))
      memory_violation_flag_next = bus_in.wdata[RCF_BIT_MEMORY_VIOLATION_FLAG];
    if (ev[RCF_EV_MEMORY_VIOLATION_FLAG])
      memory_violation_flag_next = 1'b0; // RULE_13 RULE_17
    else if (ev[RCF_EV_POR] || ev[RCF_EV_BOR])
      memory_violation_flag_next = 1'b1; // RULE_04
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      memory_violation_flag_reg <= 1'b1;
    else
      memory_violation_flag_reg <= memory_violation_flag_next;
  end

  // ----------------------------------------------------------------
  // processor status image
  // ----------------------------------------------------------------
  logic [7:0] stat_reg;
  logic [7:0] stat_next;

  // writes go first so a reset image always lands on top of them
  always_comb
  begin
    stat_next = stat_reg;
    if (hit_wr(bus_in, RCF_OFS_STAT))
      stat_next = bus_in.wdata & RCF_STAT_MASK;
    if (ev[RCF_EV_POR] || ev[RCF_EV_BOR])
      stat_next = RCF_STAT_POR; // RULE_04 RULE_05
    else if (ev[RCF_EV_WDT])
      stat_next[RCF_BIT_TO] = 1'b0; // RULE_08
    else if (ev[RCF_EV_EXTSLP])
    begin
      stat_next[RCF_BIT_TO] = 1'b1; // RULE_07
      stat_next[RCF_BIT_PD] = 1'b0; // RULE_07
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      stat_reg <= RCF_STAT_POR;
    else
      stat_reg <= stat_next;
  end

  // ----------------------------------------------------------------
  // brown-out control
  // ----------------------------------------------------------------
  logic software_brownout_enable_reg;

  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      software_brownout_enable_reg <= RCF_BORCTL_RST[RCF_BIT_SOFTWARE_BROWNOUT_ENABLE];
    else if (hit_wr(bus_in, RCF_OFS_BORCTL))
      software_brownout_enable_reg <= bus_in.wdata[RCF_BIT_SOFTWARE_BROWNOUT_ENABLE];
  end

  // ----------------------------------------------------------------
  // reset request and program counter restart
  // ----------------------------------------------------------------
  // firmware writes never reach this path, so forcing a flag is safe
  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      reset_req <= 1'b0;
      pc_clear  <= 1'b0;
    end
    else
    begin
      reset_req <= |ev; // RULE_03 RULE_16
      pc_clear  <= |ev; // RULE_04
    end
  end

  // ----------------------------------------------------------------
  // event status and interrupt
  // ----------------------------------------------------------------
  logic [RCF_NEV-1:0] evt_reg;
  logic [RCF_NEV-1:0] evt_next;
  logic [RCF_NEV-1:0] mask_reg;
  logic [RCF_NEV-1:0] mask_next;
  logic [15:0]        wword;

  assign wword = {8'h00, bus_in.wdata};

  // set wins over a clear written in the same cycle
  always_comb
  begin
    evt_next = evt_reg;
    if (hit_wr(bus_in, RCF_OFS_EVT))
      evt_next = evt_next & ~wword[RCF_NEV-1:0];
    evt_next = evt_next | ev;
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      evt_reg <= RCF_EVT_RST;
    else
      evt_reg <= evt_next;
  end

  // only the low eight events are maskable from the byte-wide bus;
  // the two upper events stay enabled once any mask is written
  always_comb
  begin
    mask_next = mask_reg;
    if (hit_wr(bus_in, RCF_OFS_MASK))
      mask_next = {2'b11, bus_in.wdata};
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      mask_reg <= RCF_EVT_RST;
    else
      mask_reg <= mask_next;
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      irq <= 1'b0;
    else
      irq <= |(evt_reg & mask_reg);
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rd_next;
  logic [7:0] high_view;
  logic [7:0] borctl_view;

  // unimplemented bits are tied here so every read path agrees
  assign high_view   = {6'h00, memory_violation_flag_reg, 1'b0}; // RULE_15
  assign borctl_view = {software_brownout_enable_reg, 6'h00, rdy_sync_reg[1]};

  // the two upper events have no byte lane; they only reach irq
  always_comb
  begin
    rd_next = 8'h00;
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        RCF_OFS_BORCTL: rd_next = borctl_view;
        RCF_OFS_LOW:    rd_next = low_reg;
        RCF_OFS_HIGH:   rd_next = high_view; // RULE_15
        RCF_OFS_STAT:   rd_next = stat_reg;
        RCF_OFS_EVT:    rd_next = evt_reg[7:0];
        RCF_OFS_MASK:   rd_next = mask_reg[7:0];
        default:        rd_next = 8'h00;
      endcase
    end
  end

  // data stands one cycle after the strobe and is zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      rd_data <= 8'h00;
    else
      rd_data <= rd_next;
  end

endmodule : rcf_top

// File: tb/rcf_asserts.sv
`timescale 1ns/1ps
module rcf_asserts
  import rcf_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire rcf_cause_s cause_in,
  input wire logic       stack_error_reset_enable,
  input wire logic       brownout_ready,
  input wire rcf_bus_s   bus_in,
  input wire logic [7:0] rd_data,
  input wire logic       reset_req,
  input wire logic       pc_clear,
  input wire logic       irq
);
  // ----
  // port checks
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire stk = cause_in.stack_overflow | cause_in.stack_underflow;
  a_pc_follows: assert property (pc_clear == reset_req)
    else $error("pc clear differs from reset request");
  a_event_req: assert property ($rose(|{cause_in[9:3], cause_in[0]}) |-> ##[1:4] reset_req)
    else $error("event gave no reset request");
  a_req_single: assert property (reset_req |=> !reset_req)
    else $error("reset request longer than one cycle");
  a_stack_gated: assert property
    ((!stack_error_reset_enable)[*4] ##0 $rose(stk) |=> (!reset_req)[*4])
    else $error("stack event reset while disabled");
  a_high_zero: assert property
    ($past(bus_in.rd && bus_in.addr == RCF_OFS_HIGH) |-> (rd_data & 8'hfd) == 8'h00)
    else $error("unused high flag bits not zero");
  a_stat_msb: assert property ($past(bus_in.rd && bus_in.addr == RCF_OFS_STAT) |-> !rd_data[7])
    else $error("status image bit 7 set");
  a_quiet_no_req: assert property ((cause_in == '0)[*5] |-> !reset_req)
    else $error("reset request without a cause");
  a_rd_idle: assert property (!$past(bus_in.rd) |-> rd_data == 8'h00)
    else $error("read data outside read slot");
  c_req: cover property (reset_req);
  c_irq: cover property ($rose(irq));
  c_stack: cover property (stack_error_reset_enable && reset_req);
endmodule : rcf_asserts

// File: tb/rcf_src_model.sv
`timescale 1ns/1ps
module rcf_src_model
  import rcf_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       go,
  input  wire logic [3:0] sel,
  input  wire logic [2:0] hold,
  output rcf_cause_s      cause
);
  logic [3:0] cnt_reg;
  logic [3:0] sel_reg;
  // ----
  // reset sources
  // ----
  // line drops after the hold so the next rise counts as a new event
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= 4'h0;
    else if (go)
      cnt_reg <= {1'b0, hold} + 4'h1;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (go)
      sel_reg <= sel;
  end
  assign cause = rcf_cause_s'((cnt_reg != 4'h0) ? 10'h200 >> sel_reg : 10'h000);
endmodule : rcf_src_model

// File: tb/rcf_tb_top.sv
`timescale 1ns/1ps
module rcf_tb_top
  import rcf_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        ena     = 1'b0;
  logic        go      = 1'b0;
  logic [3:0]  sel     = 4'h0;
  logic [2:0]  hold    = 3'h0;
  rcf_bus_s    bus     = '0;
  rcf_cause_s  cause;
  logic [7:0]  rd_data;
  logic        reset_req;
  logic        pc_clear;
  logic        irq;
  logic [31:0] seed    = 32'h7e53;
  logic [23:0] ex;
  int          mismatches  = 0;
  int          comparisons = 0;
  rcf_top u_rcf_top (.ref_clk(ref_clk), .arst_n(arst_n), .cause_in(cause),
    .stack_error_reset_enable(ena), .brownout_ready(1'b1), .bus_in(bus),
    .rd_data(rd_data), .reset_req(reset_req), .pc_clear(pc_clear), .irq(irq));
  rcf_src_model u_rcf_src_model (.ref_clk(ref_clk), .arst_n(arst_n), .go(go),
    .sel(sel), .hold(hold), .cause(cause));
  initial forever #12.5 ref_clk = ~ref_clk;
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // expected {high, status, low} after event i
  function automatic logic [23:0] after_ev(int i, logic [23:0] v, logic en);
    logic [7:0] h, s, l;
    {h, s, l} = v;
    case (i)
      RCF_EV_POR: {h, s, l} = {8'h02, 8'h60, 8'h3c};
      RCF_EV_BOR: {h[1], s, l} = {1'b1, 8'h60, 6'h0f, l[1], 1'b0};
      RCF_EV_EXT: l[3] = 1'b0;
      RCF_EV_EXTSLP: {l[3], s[6:5]} = 3'b010;
      RCF_EV_WDT: {l[4], s[6]} = 2'b00;
      RCF_EV_WV: l[5] = 1'b0;
      RCF_EV_RI: l[2] = 1'b0;
      RCF_EV_OVF: l[7] = l[7] | en;
      RCF_EV_UNF: l[6] = l[6] | en;
      default: h[1] = 1'b0;
    endcase
    return {h, s, l};
  endfunction : after_ev
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rdc(logic [3:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rdc
  // fixed watch window: a missing pulse is a mismatch, never a hang
  task automatic fire(int i, logic want);
    logic got;
    got = 1'b0;
    seed = xs(seed);
    @(posedge ref_clk);
    {sel, hold, go} <= {4'(i), seed[2:0], 1'b1};
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (12)
    begin
      @(posedge ref_clk);
      #1 got |= reset_req;
    end
    chk({7'h00, got}, {7'h00, want});
    ex = after_ev(i, ex, want);
  endtask : fire
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ex = {8'h02, 8'h60, 8'h3c};
    rdc(RCF_OFS_LOW, 8'h3c);
    rdc(RCF_OFS_HIGH, 8'h02);
    rdc(RCF_OFS_STAT, 8'h60);
    rdc(RCF_OFS_BORCTL, 8'h81);
    rdc(4'hf, 8'h00);
    $display("test reset values done");
    for (int p = 0; p < 2; p++)
    begin
      ena <= p[0];
      for (int i = 0; i < RCF_NEV; i++)
      begin
        seed = xs(seed);
        wr(RCF_OFS_LOW, seed[7:0]);
        wr(RCF_OFS_HIGH, seed[15:8]);
        ex = {seed[15:8] & 8'h02, ex[15:8], seed[7:0]};
        fire(i, (i != RCF_EV_OVF && i != RCF_EV_UNF) || p == 1);
        rdc(RCF_OFS_LOW, ex[7:0]);
        rdc(RCF_OFS_HIGH, ex[23:16]);
        rdc(RCF_OFS_STAT, ex[15:8]);
      end
      chk({7'h00, irq}, {7'h00, p[0]});
      rdc(RCF_OFS_EVT, p ? 8'hff : 8'h7f);
      wr(RCF_OFS_MASK, 8'hff);
      wr(RCF_OFS_EVT, 8'hff);
      rdc(RCF_OFS_EVT, 8'h00);
      $display("test event pass %0d done", p);
    end
    wr(4'hf, 8'h55);
    rdc(RCF_OFS_LOW, ex[7:0]);
    end_of_test();
  end
endmodule : rcf_tb_top
bind rcf_top rcf_asserts u_rcf_asserts (.ref_clk(ref_clk), .arst_n(arst_n),
  .cause_in(cause_in), .stack_error_reset_enable(stack_error_reset_enable),
  .brownout_ready(brownout_ready), .bus_in(bus_in), .rd_data(rd_data),
  .reset_req(reset_req), .pc_clear(pc_clear), .irq(irq));
